// >>> inc/hpsrb_pkg.sv
package hpsrb_pkg;

  // ----------------------------------------------------------------
  // Register command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SLOT_A_CONTROL = 8'h02;
  localparam logic [7:0] CMD_SLOT_B_CONTROL = 8'h03;
  localparam logic [7:0] CMD_SLOT_A_STATUS = 8'h04;
  localparam logic [7:0] CMD_SLOT_B_STATUS = 8'h05;
  localparam logic [7:0] CMD_SHARED_STATUS = 8'h06;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_CTRL = 3'h0;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_AUX_EN = 0;
  localparam int CTRL_MAIN_EN = 1;
  localparam int CTRL_GATE = 2;
  localparam int CTRL_MAIN_GOOD = 6;
  localparam int CTRL_AUX_GOOD = 7;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int STAT_LOW_OC = 0;
  localparam int STAT_HIGH_OC = 2;
  localparam int STAT_AUX_OC = 4;
  localparam int STAT_AUX_ON = 5;
  localparam int STAT_MAIN_ON = 6;
  localparam int STAT_FAULT = 7;

  // ----------------------------------------------------------------
  // Shared status fields
  // ----------------------------------------------------------------
  localparam int SHARED_INT_MASK = 3;

  // ----------------------------------------------------------------
  // Serial port constants
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_FIXED = 4'h8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  typedef enum logic [3:0] {
    HPSRB_IDLE,
    HPSRB_ADDR,
    HPSRB_ACK_ADDR,
    HPSRB_CMD,
    HPSRB_ACK_CMD,
    HPSRB_WDATA,
    HPSRB_ACK_WDATA,
    HPSRB_RDATA,
    HPSRB_RACK_WAIT,
    HPSRB_RACK,
    HPSRB_RNEXT
  } hpsrb_state_t;

  // Supply monitor inputs of slot A
  typedef struct packed {
    logic aux_good;
    logic main_good;
    logic oc_aux;
    logic oc_high;
    logic oc_low;
  } hpsrb_supply_t;

endpackage

// >>> core/hpsrb_top.sv
`timescale 1ns/1ps
module hpsrb_top (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic [2:0] i_addr_strap,
  input wire logic i_override_pin_n,
  input wire logic i_main_request_pin,
  input wire logic i_aux_request_pin,
  input wire logic i_management_bus_control,
  input wire hpsrb_pkg::hpsrb_supply_t i_supply,
  output logic o_main_power_on,
  output logic o_aux_power_on,
  output logic o_power_good_o,
  output logic o_power_good_oe,
  output logic o_slot_fault_o,
  output logic o_slot_fault_oe,
  output logic o_int_o,
  output logic o_int_oe
);
  import hpsrb_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = 14;
  // Reset to idle pin levels so no false edge or event follows release
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {2'h3, 3'h0, 1'h1, 3'h0, 5'h0};
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic scl_prev_q;
  logic sda_prev_q;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= {i_scl, i_sda, i_addr_strap, i_override_pin_n,
                  i_main_request_pin, i_aux_request_pin,
                  i_management_bus_control, i_supply};
      sync2_q <= sync1_q;
    end
  end

  logic scl_s;
  logic sda_s;
  logic [2:0] strap_s;
  logic override_n_s;
  logic main_req_s;
  logic aux_req_s;
  logic bus_mode_s;
  hpsrb_supply_t sup_s;

  assign {scl_s, sda_s, strap_s, override_n_s, main_req_s, aux_req_s,
          bus_mode_s, sup_s} = sync2_q;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ----------------------------------------------------------------
  // Address strap capture
  // ----------------------------------------------------------------
  logic [2:0] strap_q;
  logic strap_taken_q;
  logic [1:0] strap_fill_q;

  // Wait until the synchroniser holds real pin levels
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      strap_q <= 3'h0;
      strap_taken_q <= 1'b0;
      strap_fill_q <= '0;
    end else begin
      strap_fill_q <= {strap_fill_q[0], 1'b1};
      if (strap_fill_q[1] && !strap_taken_q) begin
        strap_q <= strap_s;
        strap_taken_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [2:0] ctrl_a_q;
  logic [2:0] ctrl_b_q;
  logic int_mask_q;
  logic aux_oc_q;
  logic high_oc_q;
  logic low_oc_q;
  logic main_trip_q;
  logic aux_trip_q;
  logic wr_q;
  logic [7:0] ptr_q;
  logic [7:0] wdata_q;

  logic force_on;
  logic aux_enable;
  logic main_enable;
  logic main_on;
  logic aux_on;
  logic fault_bit;

  // Force-on acts only while its gate bit is clear
  assign force_on = ~override_n_s & ~ctrl_a_q[CTRL_GATE];
  assign aux_enable = bus_mode_s ? ctrl_a_q[CTRL_AUX_EN] : aux_req_s;
  assign main_enable = bus_mode_s ? ctrl_a_q[CTRL_MAIN_EN] : main_req_s;
  assign main_on = force_on | (main_enable & ~main_trip_q);
  assign aux_on = force_on | (aux_enable & ~aux_trip_q);
  // Not touched by register reads or flag clears
  assign fault_bit = ~bus_mode_s & (main_trip_q | aux_trip_q);

  function automatic logic wr_hit(input logic [7:0] code, input int bitn);
    wr_hit = wr_q && ptr_q == code && wdata_q[bitn];
  endfunction

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_a_q <= RST_CTRL;
      ctrl_b_q <= RST_CTRL;
      int_mask_q <= 1'b0;
    end else if (wr_q) begin
      // Only writable bits are stored
      case (ptr_q)
        CMD_SLOT_A_CONTROL: ctrl_a_q <= wdata_q[2:0];
        CMD_SLOT_B_CONTROL: ctrl_b_q <= wdata_q[2:0];
        CMD_SHARED_STATUS: int_mask_q <= wdata_q[SHARED_INT_MASK];
        default: ctrl_a_q <= ctrl_a_q;
      endcase
    end
  end

  // Sticky flags; a new event wins over a clear
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      aux_oc_q <= 1'b0;
      high_oc_q <= 1'b0;
      low_oc_q <= 1'b0;
    end else begin
      if (sup_s.oc_aux && aux_enable) begin
        aux_oc_q <= 1'b1;
      end else if (wr_hit(CMD_SLOT_A_STATUS, STAT_AUX_OC)) begin
        aux_oc_q <= 1'b0;
      end
      if (sup_s.oc_high && main_enable) begin
        high_oc_q <= 1'b1;
      end else if (wr_hit(CMD_SLOT_A_STATUS, STAT_HIGH_OC)) begin
        high_oc_q <= 1'b0;
      end
      if (sup_s.oc_low && main_enable) begin
        low_oc_q <= 1'b1;
      end else if (wr_hit(CMD_SLOT_A_STATUS, STAT_LOW_OC)) begin
        low_oc_q <= 1'b0;
      end
    end
  end

  // Trip latches that shut supplies and, outside bus control mode, drive the fault pin
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      main_trip_q <= 1'b0;
      aux_trip_q <= 1'b0;
    end else begin
      if (!main_enable) begin
        main_trip_q <= 1'b0;
      end else if (sup_s.oc_high || sup_s.oc_low) begin
        main_trip_q <= 1'b1;
      end
      if (!aux_enable) begin
        aux_trip_q <= 1'b0;
      end else if (sup_s.oc_aux) begin
        aux_trip_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_main_power_on <= 1'b0;
      o_aux_power_on <= 1'b0;
      o_power_good_o <= 1'b0;
      o_power_good_oe <= 1'b0;
      o_slot_fault_o <= 1'b0;
      o_slot_fault_oe <= 1'b0;
      o_int_o <= 1'b0;
      o_int_oe <= 1'b0;
    end else begin
      o_main_power_on <= main_on;
      o_aux_power_on <= aux_on;
      o_power_good_o <= 1'b1;
      o_power_good_oe <= sup_s.aux_good & sup_s.main_good & ~force_on;
      o_slot_fault_o <= 1'b0;
      o_slot_fault_oe <= fault_bit & override_n_s;
      o_int_o <= 1'b0;
      o_int_oe <= ~int_mask_q & (aux_oc_q | high_oc_q | low_oc_q);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_reg(input logic [7:0] code);
    logic [7:0] v;
    v = READ_ZERO;
    case (code)
      CMD_SLOT_A_CONTROL: begin
        v[2:0] = ctrl_a_q;
        v[CTRL_AUX_GOOD] = sup_s.aux_good;
        v[CTRL_MAIN_GOOD] = sup_s.main_good;
      end
      CMD_SLOT_B_CONTROL: v[2:0] = ctrl_b_q;
      CMD_SLOT_A_STATUS: begin
        v[STAT_FAULT] = fault_bit;
        v[STAT_MAIN_ON] = main_on;
        v[STAT_AUX_ON] = aux_on;
        v[STAT_AUX_OC] = aux_oc_q;
        v[STAT_HIGH_OC] = high_oc_q;
        v[STAT_LOW_OC] = low_oc_q;
      end
      CMD_SHARED_STATUS: v[SHARED_INT_MASK] = int_mask_q;
      default: v = READ_ZERO;
    endcase
    read_reg = v;
  endfunction

  logic [7:0] rd_byte;
  assign rd_byte = read_reg(ptr_q);

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  hpsrb_state_t state_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic ack_on_q;
  logic rw_q;
  logic [7:0] shift_in;
  assign shift_in = {shift_q[6:0], sda_s};

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= HPSRB_IDLE;
      bit_q <= BIT_FIRST;
      shift_q <= RST_BYTE;
      ack_on_q <= 1'b0;
      rw_q <= 1'b0;
      ptr_q <= RST_BYTE;
      wdata_q <= RST_BYTE;
      wr_q <= 1'b0;
      o_sda_o <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      o_sda_o <= 1'b0;
      if (start_det) begin
        state_q <= HPSRB_ADDR;
        bit_q <= BIT_FIRST;
        ack_on_q <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (stop_det) begin
        state_q <= HPSRB_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state_q)
          HPSRB_ADDR, HPSRB_CMD, HPSRB_WDATA: begin
            if (scl_rise) begin
              shift_q <= shift_in;
              bit_q <= bit_q + 3'h1;
              if (bit_q == BIT_LAST) begin
                case (state_q)
                  HPSRB_ADDR: begin
                    rw_q <= sda_s;
                    if (shift_in[7:1] == {ADDR_FIXED, strap_q}) begin
                      state_q <= HPSRB_ACK_ADDR;
                    end else begin
                      state_q <= HPSRB_IDLE;
                    end
                  end
                  HPSRB_CMD: begin
                    ptr_q <= shift_in;
                    state_q <= HPSRB_ACK_CMD;
                  end
                  default: begin
                    wdata_q <= shift_in;
                    wr_q <= 1'b1;
                    state_q <= HPSRB_ACK_WDATA;
                  end
                endcase
              end
            end
          end
          HPSRB_ACK_ADDR, HPSRB_ACK_CMD, HPSRB_ACK_WDATA: begin
            if (scl_fall) begin
              ack_on_q <= ~ack_on_q;
              bit_q <= BIT_FIRST;
              if (!ack_on_q) begin
                o_sda_oe <= 1'b1;
              end else if (state_q == HPSRB_ACK_ADDR && rw_q) begin
                shift_q <= rd_byte;
                o_sda_oe <= ~rd_byte[7];
                state_q <= HPSRB_RDATA;
              end else begin
                o_sda_oe <= 1'b0;
                state_q <= (state_q == HPSRB_ACK_ADDR) ? HPSRB_CMD
                                                       : HPSRB_WDATA;
              end
            end
          end
          HPSRB_RDATA: begin
            if (scl_rise) begin
              bit_q <= bit_q + 3'h1;
              if (bit_q == BIT_LAST) begin
                state_q <= HPSRB_RACK_WAIT;
              end
            end else if (scl_fall) begin
              shift_q <= {shift_q[6:0], 1'b0};
              o_sda_oe <= ~shift_q[6];
            end
          end
          HPSRB_RACK_WAIT: begin
            if (scl_fall) begin
              o_sda_oe <= 1'b0;
              state_q <= HPSRB_RACK;
            end
          end
          HPSRB_RACK: begin
            if (scl_rise) begin
              state_q <= sda_s ? HPSRB_IDLE : HPSRB_RNEXT;
            end
          end
          HPSRB_RNEXT: begin
            if (scl_fall) begin
              shift_q <= rd_byte;
              o_sda_oe <= ~rd_byte[7];
              bit_q <= BIT_FIRST;
              state_q <= HPSRB_RDATA;
            end
          end
          default: begin
            state_q <= HPSRB_IDLE;
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// >>> verification/hpsrb_host_model.sv
`timescale 1ns/1ps
module hpsrb_host_model (
  input wire logic i_mclk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // ----------------------------------------------------------------
  // Bus phases, six clocks each, changed after falling edges
  // ----------------------------------------------------------------
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic hw();
    repeat (6) @(negedge i_mclk);
  endtask
  task automatic start();
    hw();
    o_sda_low = 1'b0;
    hw();
    o_scl = 1'b1;
    hw();
    o_sda_low = 1'b1;
    hw();
    o_scl = 1'b0;
  endtask
  task automatic stop();
    hw();
    o_sda_low = 1'b1;
    hw();
    o_scl = 1'b1;
    hw();
    o_sda_low = 1'b0;
    hw();
  endtask
  task automatic bit_io(input logic b, output logic r);
    hw();
    o_sda_low = !b;
    hw();
    o_scl = 1'b1;
    hw();
    r = i_sda;
    o_scl = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] b, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], a);
      r[i] = a;
    end
  endtask
  // ----------------------------------------------------------------
  // Write_Byte, Read_Byte and Receive_Byte
  // ----------------------------------------------------------------
  task automatic wr(input logic [6:0] a, input logic [7:0] c,
      input logic [7:0] d, output logic nak);
    logic [7:0] r;
    logic k0, k1, k2;
    start();
    byte_io({a, 1'b0}, r);
    bit_io(1'b1, k0);
    byte_io(c, r);
    bit_io(1'b1, k1);
    byte_io(d, r);
    bit_io(1'b1, k2);
    stop();
    nak = k0 | k1 | k2;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c,
      input logic recv, output logic [7:0] d);
    logic [7:0] r;
    logic k;
    start();
    if (!recv) begin
      byte_io({a, 1'b0}, r);
      bit_io(1'b1, k);
      byte_io(c, r);
      bit_io(1'b1, k);
      start();
    end
    byte_io({a, 1'b1}, r);
    bit_io(1'b1, k);
    byte_io(8'hFF, d);
    bit_io(1'b1, k);
    stop();
  endtask
endmodule

// >>> verification/hpsrb_top_asserts.sv
`timescale 1ns/1ps
module hpsrb_top_asserts
  import hpsrb_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_override_pin_n,
  input wire logic i_main_request_pin,
  input wire logic i_aux_request_pin,
  input wire logic i_management_bus_control,
  input wire hpsrb_pkg::hpsrb_supply_t i_supply,
  input wire logic o_sda_oe,
  input wire logic o_main_power_on,
  input wire logic o_aux_power_on,
  input wire logic o_power_good_oe,
  input wire logic o_slot_fault_oe
);
  // ----------------------------------------------------------------
  // Pin relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  property p_fault_ovr;
    (!i_override_pin_n)[*5] |-> !o_slot_fault_oe;
  endproperty
  a_fault_ovr: assert property (p_fault_ovr)
    else $error("fault pin held under force-on");
  property p_pg_bad;
    (!i_supply.aux_good || !i_supply.main_good)[*5] |-> !o_power_good_oe;
  endproperty
  a_pg_bad: assert property (p_pg_bad)
    else $error("power good driven while not good");
  property p_pg_good;
    (i_supply.aux_good && i_supply.main_good && i_override_pin_n)[*5]
      |-> o_power_good_oe;
  endproperty
  a_pg_good: assert property (p_pg_good)
    else $error("power good not driven");
  property p_bus_nofault;
    i_management_bus_control[*5] |-> !o_slot_fault_oe;
  endproperty
  a_bus_nofault: assert property (p_bus_nofault)
    else $error("fault pin active in bus mode");
  property p_fault_clr;
    (!i_management_bus_control && !i_main_request_pin
      && !i_aux_request_pin)[*5] |-> !o_slot_fault_oe;
  endproperty
  a_fault_clr: assert property (p_fault_clr)
    else $error("fault pin kept with requests low");
  property p_main_off;
    (!i_management_bus_control && !i_main_request_pin
      && i_override_pin_n)[*5] |-> !o_main_power_on;
  endproperty
  a_main_off: assert property (p_main_off)
    else $error("main on without request");
  property p_aux_off;
    (!i_management_bus_control && !i_aux_request_pin
      && i_override_pin_n)[*5] |-> !o_aux_power_on;
  endproperty
  a_aux_off: assert property (p_aux_off)
    else $error("aux on without request");
  property p_sda_low;
    $rose(o_sda_oe) |-> !i_scl;
  endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("data pulled while clock high");
endmodule
bind hpsrb_top hpsrb_top_asserts u_hpsrb_top_asserts (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_scl(i_scl),
  .i_override_pin_n(i_override_pin_n),
  .i_main_request_pin(i_main_request_pin),
  .i_aux_request_pin(i_aux_request_pin),
  .i_management_bus_control(i_management_bus_control),
  .i_supply(i_supply), .o_sda_oe(o_sda_oe),
  .o_main_power_on(o_main_power_on), .o_aux_power_on(o_aux_power_on),
  .o_power_good_oe(o_power_good_oe), .o_slot_fault_oe(o_slot_fault_oe)
);

// >>> verification/tb_hpsrb_top.sv
`timescale 1ns/1ps
module tb_hpsrb_top;
  import hpsrb_pkg::*;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [6:0] ADDR = {ADDR_FIXED, STRAP};
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic ovr_n = 1'b1;
  logic mreq = 1'b0;
  logic areq = 1'b0;
  logic mbc = 1'b1;
  hpsrb_supply_t sup = 5'h0;
  logic scl, h_low, sda_oe, m_on, a_on, pg_oe, f_oe, i_oe, nak;
  logic pg_o, f_o, int_o, sda_o;
  logic [7:0] d;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  wire sda = !(h_low || sda_oe);
  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  always #4 i_mclk = ~i_mclk;
  hpsrb_top u_hpsrb_top (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_addr_strap(STRAP),
    .i_override_pin_n(ovr_n), .i_main_request_pin(mreq),
    .i_aux_request_pin(areq), .i_management_bus_control(mbc),
    .i_supply(sup), .o_main_power_on(m_on), .o_aux_power_on(a_on),
    .o_power_good_o(pg_o), .o_power_good_oe(pg_oe), .o_slot_fault_o(f_o),
    .o_slot_fault_oe(f_oe), .o_int_o(int_o), .o_int_oe(i_oe)
  );
  hpsrb_host_model u_hpsrb_host_model (
    .i_mclk(i_mclk), .i_sda(sda), .o_scl(scl), .o_sda_low(h_low)
  );
  // ----------------------------------------------------------------
  // Checks and bus calls
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      $display("Error at %0t: run too long", $time);
      wrap_up();
    end
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: read %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: pin %b, want %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    u_hpsrb_host_model.wr(ADDR, c, v, nak);
    chk_pin(nak, 1'b0);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    u_hpsrb_host_model.rd(ADDR, c, 1'b0, d);
    chk_byte(d, exp);
  endtask
  task automatic settle();
    repeat (5) @(negedge i_mclk);
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    i_reset = 1'b0;
    settle();
    for (int c = 2; c < 7; c++) begin
      rd(8'(c), RST_BYTE);
    end
    chk_pin(m_on | a_on, 1'b0);
    chk_byte({4'h0, pg_o, f_o, int_o, sda_o}, 8'h08);
    $display("test reset done");
    wr(CMD_SLOT_A_CONTROL, 8'h01);
    chk_pin(a_on & !m_on, 1'b1);
    wr(CMD_SLOT_A_CONTROL, 8'h02);
    chk_pin(m_on & !a_on, 1'b1);
    wr(CMD_SLOT_A_CONTROL, 8'hFF);
    rd(CMD_SLOT_A_CONTROL, 8'h07);
    sup.aux_good = 1'b1;
    settle();
    rd(CMD_SLOT_A_CONTROL, 8'h87);
    chk_pin(pg_oe, 1'b0);
    sup.main_good = 1'b1;
    settle();
    rd(CMD_SLOT_A_CONTROL, 8'hC7);
    chk_pin(pg_oe, 1'b1);
    rd(CMD_SLOT_A_STATUS, 8'h60);
    ovr_n = 1'b0;
    settle();
    chk_pin(pg_oe, 1'b1);
    wr(CMD_SLOT_A_CONTROL, 8'h03);
    chk_pin(pg_oe, 1'b0);
    rd(CMD_SLOT_A_CONTROL, 8'hC3);
    ovr_n = 1'b1;
    settle();
    $display("test bus control done");
    sup.oc_low = 1'b1;
    settle();
    sup.oc_low = 1'b0;
    settle();
    rd(CMD_SLOT_A_STATUS, 8'h21);
    chk_pin(i_oe, 1'b1);
    wr(CMD_SHARED_STATUS, 8'h08);
    chk_pin(i_oe, 1'b0);
    rd(CMD_SHARED_STATUS, 8'h08);
    wr(CMD_SHARED_STATUS, 8'h00);
    chk_pin(i_oe, 1'b1);
    wr(CMD_SLOT_A_STATUS, 8'h00);
    rd(CMD_SLOT_A_STATUS, 8'h21);
    wr(CMD_SLOT_A_STATUS, 8'h01);
    chk_pin(i_oe, 1'b0);
    rd(CMD_SLOT_A_STATUS, 8'h20);
    wr(CMD_SLOT_A_CONTROL, 8'h00);
    $display("test bus fault done");
    mbc = 1'b0;
    mreq = 1'b1;
    areq = 1'b1;
    settle();
    chk_pin(m_on & a_on, 1'b1);
    sup.oc_high = 1'b1;
    settle();
    sup.oc_high = 1'b0;
    settle();
    chk_pin(f_oe, 1'b1);
    rd(CMD_SLOT_A_STATUS, 8'hA4);
    wr(CMD_SLOT_A_STATUS, 8'h04);
    chk_pin(f_oe, 1'b1);
    rd(CMD_SLOT_A_STATUS, 8'hA0);
    ovr_n = 1'b0;
    settle();
    chk_pin(f_oe, 1'b0);
    u_hpsrb_host_model.rd(ADDR, CMD_SLOT_A_STATUS, 1'b0, d);
    chk_byte(d & 8'h80, 8'h80);
    ovr_n = 1'b1;
    areq = 1'b0;
    settle();
    chk_pin(f_oe, 1'b1);
    mreq = 1'b0;
    settle();
    chk_pin(f_oe, 1'b0);
    mreq = 1'b1;
    areq = 1'b1;
    sup.oc_aux = 1'b1;
    settle();
    sup.oc_aux = 1'b0;
    mreq = 1'b0;
    settle();
    chk_pin(f_oe, 1'b1);
    areq = 1'b0;
    settle();
    chk_pin(f_oe, 1'b0);
    rd(CMD_SLOT_A_STATUS, 8'h10);
    wr(CMD_SLOT_A_STATUS, 8'h10);
    chk_pin(i_oe, 1'b0);
    $display("test pin control done");
    u_hpsrb_host_model.wr({ADDR_FIXED, 3'h2}, CMD_SLOT_B_CONTROL,
      8'h05, nak);
    chk_pin(nak, 1'b1);
    rd(CMD_SLOT_B_CONTROL, RST_BYTE);
    wr(CMD_SLOT_B_CONTROL, 8'h05);
    rd(CMD_SLOT_B_CONTROL, 8'h05);
    u_hpsrb_host_model.rd(ADDR, RST_BYTE, 1'b1, d);
    chk_byte(d, 8'h05);
    $display("test address done");
    wrap_up();
  end
endmodule
